// >>> rtl/od_sleep_controller.sv
// Purpose: Controller end: AHB-Lite registers that issue device commands
// Assumes: Zero-wait slave, single word transfers, response always OKAY
// Notes:   Control writes are held back while the device is in wake reset
`timescale 1ns/1ns
`include "sleep_ctl_map.svh"
module od_sleep_controller (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  sleep_link_if.controller link
);
  import sleep_ctl_pkg::*;

  logic        ap_write;
  logic        next_ap_write;
  logic [7:0]  ap_addr;
  logic [7:0]  next_ap_addr;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic        pending;
  logic        next_pending;
  logic        kind;
  logic        next_kind;
  byte_t       data;
  byte_t       next_data;
  logic        valid;
  logic        next_valid;
  logic        last_refused;
  logic        next_last_refused;

  logic        take;

  // Read mux shared by the address phase
  function automatic logic [31:0] read_word(input logic [7:0] ofs);
    logic [31:0] w;
    w = 32'h0;
    unique case (ofs)
      `OFS_COMMAND: begin
        w[`CMD_KIND_BIT]  = kind;
        w[7:0]            = data;
      end
      `OFS_STATUS: begin
        w[`HST_BUSY_BIT]    = pending;
        w[`HST_REFUSED_BIT] = last_refused;
        w[`HST_DEV_LSB +: 8] = link.dev_status;
      end
      `OFS_CONFIG_RB:  w[7:0] = link.dev_config;
      `OFS_CONTROL_RB: w[7:0] = link.dev_control;
      default:         w = 32'h0;
    endcase
    return w;
  endfunction : read_word

  assign take = hsel & htrans[1] & hready;

  // Bus phases and command launch
  always_comb begin
    next_ap_write     = take & hwrite;
    next_ap_addr      = haddr[7:0];
    next_rdata        = take ? read_word(haddr[7:0]) : 32'h0;
    next_pending      = pending;
    next_kind         = kind;
    next_data         = data;
    next_last_refused = last_refused;
    if (ap_write && ap_addr == `OFS_COMMAND && !pending) begin
      next_pending = 1'b1;
      next_kind    = hwdata[`CMD_KIND_BIT];
      next_data    = hwdata[7:0];
    end
    // Done closes the request even if valid was withheld after the take
    if (pending && link.cmd_done) begin
      next_pending      = 1'b0;
      next_last_refused = link.cmd_refused;
    end
    // Control writes wait out the wake reset
    next_valid = next_pending & ~(pending & link.cmd_done)
               & (next_kind | ~link.dev_status[`ST_WAKING_BIT]);
  end

  // Registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_write     <= 1'b0;
      ap_addr      <= 8'h00;
      rdata        <= 32'h0;
      pending      <= 1'b0;
      kind         <= 1'b0;
      data         <= 8'h00;
      valid        <= 1'b0;
      last_refused <= 1'b0;
    end else begin
      ap_write     <= next_ap_write;
      ap_addr      <= next_ap_addr;
      rdata        <= next_rdata;
      pending      <= next_pending;
      kind         <= next_kind;
      data         <= next_data;
      valid        <= next_valid;
      last_refused <= next_last_refused;
    end
  end

  // Outputs from flip-flops; zero-wait OKAY slave
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  assign hrdata             = rdata;
  assign link.cmd_valid     = valid;
  assign link.cmd_is_config = kind;
  assign link.cmd_data      = data;
endmodule : od_sleep_controller

// >>> rtl/od_sleep_device.sv
// Purpose: Over-discharge detection, release and sleep sequencing
// Assumes: Comparator and wake inputs are synchronous to hclk
// Notes:   FET drive high means FET off
`timescale 1ns/1ns
`include "sleep_ctl_map.svh"
module od_sleep_device #(
  parameter int unsigned DETECT_CYCLES  = `UV_DETECT_CYCLES,
  parameter int unsigned RELEASE_CYCLES = `UV_RELEASE_CYCLES,
  parameter int unsigned WAKE_CYCLES    = `WAKE_RESET_CYCLES
) (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  sleep_link_if.device    link,
  input  wire logic [3:0] cell_below_uv,
  input  wire logic [3:0] cell_above_uvr,
  input  wire logic [3:0] cell_above_gate,
  input  wire logic       pack_at_wake,
  output logic [1:0]      undervoltage_level_select,
  output logic [1:0]      charge_gate_level_select,
  output logic            discharge_fet_drive,
  output logic            charge_fet_drive,
  output logic            regulated_output
);
  import sleep_ctl_pkg::*;

  dev_state_t  state;
  dev_state_t  next_state;
  logic [31:0] cnt;
  logic [31:0] next_cnt;
  logic [31:0] rel_cnt;
  logic [31:0] next_rel_cnt;
  byte_t       cfg;
  byte_t       next_cfg;
  byte_t       ctl;
  byte_t       next_ctl;
  logic        od_flag;
  logic        next_od_flag;
  logic        gate_pending;
  logic        next_gate_pending;
  logic        done;
  logic        next_done;
  logic        refused;
  logic        next_refused;
  logic        dsg_drive;
  logic        next_dsg_drive;
  logic        chg_drive;
  logic        next_chg_drive;
  logic        reg_on;
  logic        next_reg_on;
  byte_t       status;
  byte_t       next_status;

  logic any_below;
  logic all_released;
  logic gate_ok;
  logic fet_lock;
  logic can_sleep;

  // Condition terms from the synchronous comparator inputs
  assign any_below    = |cell_below_uv;
  assign all_released = &cell_above_uvr;
  assign gate_ok      = cfg[`CFG_GATE_DIS_BIT] | (&cell_above_gate);
  assign fet_lock     = gate_pending & ~gate_ok;
  assign can_sleep    = ~pack_at_wake;

  // Next-state logic: sequencing, timers, command handling, drives
  always_comb begin
    next_state        = state;
    next_cnt          = cnt;
    next_rel_cnt      = rel_cnt;
    next_cfg          = cfg;
    next_ctl          = ctl;
    next_od_flag      = od_flag;
    next_gate_pending = gate_pending;
    next_done         = 1'b0;
    next_refused      = 1'b0;

    unique case (state)
      ST_NORMAL: begin
        if (any_below && !od_flag) begin
          next_state = ST_DETECT;
          next_cnt   = 32'h0;
        end
        if (gate_ok) begin
          next_gate_pending = 1'b0;
        end
      end
      ST_DETECT: begin
        if (!any_below) begin
          next_state = ST_NORMAL;
        end else if (cnt == DETECT_CYCLES - 1) begin
          next_od_flag                = 1'b1;
          next_ctl[`CTL_CHG_EN_BIT]   = 1'b0;
          next_ctl[`CTL_DSG_EN_BIT]   = 1'b0;
          next_state = can_sleep ? ST_SLEEP : ST_NORMAL;
        end else begin
          next_cnt = cnt + 32'h1;
        end
      end
      ST_SLEEP: begin
        if (pack_at_wake) begin
          next_state        = ST_WAKE;
          next_cnt          = 32'h0;
          next_gate_pending = 1'b1;
        end
      end
      ST_WAKE: begin
        if (cnt == WAKE_CYCLES - 1) begin
          next_state = ST_NORMAL;
        end else begin
          next_cnt = cnt + 32'h1;
        end
      end
    endcase

    // Release timer runs once charge is back on and every cell is released
    if (od_flag && state == ST_NORMAL && ctl[`CTL_CHG_EN_BIT] && all_released) begin
      if (rel_cnt == RELEASE_CYCLES - 1) begin
        next_od_flag = 1'b0;
        next_rel_cnt = 32'h0;
      end else begin
        next_rel_cnt = rel_cnt + 32'h1;
      end
    end else begin
      next_rel_cnt = 32'h0;
    end

    // Serial commands: one answer per held request
    if (link.cmd_valid && !done) begin
      next_done = 1'b1;
      if (state == ST_SLEEP) begin
        next_refused = 1'b1;
      end else if (link.cmd_is_config) begin
        next_cfg = link.cmd_data;
      end else begin
        if (state != ST_WAKE && !fet_lock) begin
          next_ctl[`CTL_CHG_EN_BIT] = link.cmd_data[`CTL_CHG_EN_BIT];
          if (!od_flag || !link.cmd_data[`CTL_DSG_EN_BIT]) begin
            next_ctl[`CTL_DSG_EN_BIT] = link.cmd_data[`CTL_DSG_EN_BIT];
          end
        end
        if (link.cmd_data[`CTL_SLEEP_BIT] && can_sleep) begin
          next_state = ST_SLEEP;
        end
      end
    end

    // Enable bits are dropped on any sleep entry so a wake starts with FETs off
    if (next_state == ST_SLEEP && state != ST_SLEEP) begin
      next_ctl[`CTL_CHG_EN_BIT] = 1'b0;
      next_ctl[`CTL_DSG_EN_BIT] = 1'b0;
    end

    // FET drives and regulator follow the registered state
    if (state == ST_SLEEP || state == ST_WAKE || fet_lock) begin
      next_chg_drive = 1'b1;
      next_dsg_drive = 1'b1;
    end else begin
      next_chg_drive = ~ctl[`CTL_CHG_EN_BIT];
      next_dsg_drive = ~(ctl[`CTL_DSG_EN_BIT] & ~od_flag);
    end
    next_reg_on = (state != ST_SLEEP);

    // Status bits other than lock follow the state registers edge for edge, so a command taken
    // in the cycle of a sleep entry or exit agrees with the asleep flag
    next_status                 = 8'h00;
    next_status[`ST_ASLEEP_BIT] = (next_state == ST_SLEEP);
    next_status[`ST_WAKING_BIT] = (next_state == ST_WAKE);
    next_status[`ST_OD_BIT]     = next_od_flag;
    next_status[`ST_LOCK_BIT]   = fet_lock;
    next_status[`ST_DETECT_BIT] = (next_state == ST_DETECT);
  end

  // State registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state        <= ST_NORMAL;
      cnt          <= 32'h0;
      rel_cnt      <= 32'h0;
      cfg          <= `CFG_RESET;
      ctl          <= `CTL_RESET;
      od_flag      <= 1'b0;
      gate_pending <= 1'b0;
      done         <= 1'b0;
      refused      <= 1'b0;
      dsg_drive    <= 1'b1;
      chg_drive    <= 1'b1;
      reg_on       <= 1'b1;
      status       <= 8'h00;
    end else begin
      state        <= next_state;
      cnt          <= next_cnt;
      rel_cnt      <= next_rel_cnt;
      cfg          <= next_cfg;
      ctl          <= next_ctl;
      od_flag      <= next_od_flag;
      gate_pending <= next_gate_pending;
      done         <= next_done;
      refused      <= next_refused;
      dsg_drive    <= next_dsg_drive;
      chg_drive    <= next_chg_drive;
      reg_on       <= next_reg_on;
      status       <= next_status;
    end
  end

  // Outputs straight from flip-flops
  assign link.cmd_done             = done;
  assign link.cmd_refused          = refused;
  assign link.dev_status           = status;
  assign link.dev_config           = cfg;
  assign link.dev_control          = ctl;
  assign discharge_fet_drive       = dsg_drive;
  assign charge_fet_drive          = chg_drive;
  assign regulated_output          = reg_on;
  assign undervoltage_level_select = cfg[`CFG_UV_SEL_LSB +: 2];
  assign charge_gate_level_select  = cfg[`CFG_CE_SEL_LSB +: 2];
endmodule : od_sleep_device

// >>> rtl/sleep_ctl_map.svh
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 100 MHz clock, 8-bit device registers, 32-bit AHB-Lite words
// Notes:   Included by both ends and by the testbench
`ifndef SLEEP_CTL_MAP_SVH
`define SLEEP_CTL_MAP_SVH

// Device configuration register fields
`define CFG_UV_SEL_LSB      0
`define CFG_CE_SEL_LSB      2
`define CFG_GATE_DIS_BIT    4
`define CFG_RESET           8'h00

// Device control register fields
`define CTL_CHG_EN_BIT      0
`define CTL_DSG_EN_BIT      1
`define CTL_SLEEP_BIT       2
`define CTL_RESET           8'h03

// Device status byte
`define ST_ASLEEP_BIT       0
`define ST_WAKING_BIT       1
`define ST_OD_BIT           2
`define ST_LOCK_BIT         3
`define ST_DETECT_BIT       4

// Timing
`define CLK_HZ              100000000
`define CYCLES_PER_MS       (`CLK_HZ / 1000)
`define UV_DETECT_DELAY_MS  1000
`define UV_RELEASE_DELAY_MS 7
`define WAKE_EXTRA_MS       200
`define UV_DETECT_CYCLES    (`UV_DETECT_DELAY_MS * `CYCLES_PER_MS)
`define UV_RELEASE_CYCLES   (`UV_RELEASE_DELAY_MS * `CYCLES_PER_MS)
`define WAKE_RESET_CYCLES   ((`UV_DETECT_DELAY_MS + `WAKE_EXTRA_MS) * `CYCLES_PER_MS)

// Controller AHB-Lite register byte offsets
`define OFS_COMMAND         8'h00
`define OFS_STATUS          8'h04
`define OFS_CONFIG_RB       8'h08
`define OFS_CONTROL_RB      8'h0c
`define CMD_KIND_BIT        8
`define HST_BUSY_BIT        0
`define HST_REFUSED_BIT     1
`define HST_DEV_LSB         8

`endif

// >>> rtl/sleep_ctl_pkg.sv
// Purpose: Shared types for the over-discharge and sleep link
// Assumes: Constants live in sleep_ctl_map.svh
// Notes:   States are binary coded
package sleep_ctl_pkg;
  typedef logic [7:0] byte_t;

  typedef enum logic [1:0] {
    ST_NORMAL = 2'b00,
    ST_DETECT = 2'b01,
    ST_SLEEP  = 2'b10,
    ST_WAKE   = 2'b11
  } dev_state_t;
endpackage : sleep_ctl_pkg

// >>> rtl/sleep_link_if.sv
// Purpose: Command link between controller and protection device
// Assumes: Both ends share hclk; valid is a level held until done
// Notes:   done and refused are one-cycle pulses from the device
`timescale 1ns/1ns
interface sleep_link_if;
  logic                 cmd_valid;
  logic                 cmd_is_config;
  sleep_ctl_pkg::byte_t cmd_data;
  logic                 cmd_done;
  logic                 cmd_refused;
  sleep_ctl_pkg::byte_t dev_status;
  sleep_ctl_pkg::byte_t dev_config;
  sleep_ctl_pkg::byte_t dev_control;

  modport device (
    input  cmd_valid, cmd_is_config, cmd_data,
    output cmd_done, cmd_refused, dev_status, dev_config, dev_control
  );
  modport controller (
    output cmd_valid, cmd_is_config, cmd_data,
    input  cmd_done, cmd_refused, dev_status, dev_config, dev_control
  );
endinterface : sleep_link_if

// >>> verification/over_discharge_sleep_control_tb_top.sv
// Purpose: Drives both ends through detection, sleep, wake and release
// Assumes: Short delay counts set by parameters below
// Notes:   Registers reached only over AHB-Lite
`timescale 1ns/1ns
`include "sleep_ctl_map.svh"
module over_discharge_sleep_control_tb_top;
  localparam int DET  = 20;
  localparam int REL  = 8;
  localparam int WAKE = 30;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, pack_at_wake;
  logic        dsg_drv, chg_drv, reg_out;
  logic [1:0]  htrans, uv_sel, gate_sel;
  logic [3:0]  cell_low, cell_rel, cell_gate;
  logic [31:0] haddr, hwdata, hrdata, rd;
  int          error_cnt = 0;
  int          n_checks = 0;

  sleep_link_if sleep_link_if_inst ();
  od_sleep_device #(.DETECT_CYCLES(DET), .RELEASE_CYCLES(REL), .WAKE_CYCLES(WAKE))
    od_sleep_device_inst (
    .hclk(hclk), .hresetn(hresetn), .link(sleep_link_if_inst), .cell_below_uv(cell_low),
    .cell_above_uvr(cell_rel), .cell_above_gate(cell_gate), .pack_at_wake(pack_at_wake),
    .undervoltage_level_select(uv_sel), .charge_gate_level_select(gate_sel),
    .discharge_fet_drive(dsg_drv), .charge_fet_drive(chg_drv), .regulated_output(reg_out));
  od_sleep_controller od_sleep_controller_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .link(sleep_link_if_inst));
  sleep_link_asserts sleep_link_asserts_inst (
    .hclk(hclk), .hresetn(hresetn), .cmd_valid(sleep_link_if_inst.cmd_valid),
    .cmd_is_config(sleep_link_if_inst.cmd_is_config), .cmd_data(sleep_link_if_inst.cmd_data),
    .cmd_done(sleep_link_if_inst.cmd_done), .cmd_refused(sleep_link_if_inst.cmd_refused),
    .dev_status(sleep_link_if_inst.dev_status), .dev_config(sleep_link_if_inst.dev_config),
    .dev_control(sleep_link_if_inst.dev_control));

  // Free-running system clock
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  task automatic summarize;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic tick(input int k);
    repeat (k) @(posedge hclk);
  endtask : tick

  // Bounded wait for hready sampled high at a rising edge
  task automatic wait_ready;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 64);
    if (hreadyout !== 1'b1) begin
      error_cnt++;
      summarize();
    end
  endtask : wait_ready

  // One single AHB-Lite word transfer; read data lands in rd
  task automatic xfer(input logic wr, input logic [7:0] ofs, input logic [31:0] wd);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr  <= {24'h0, ofs};
    wait_ready();
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask : xfer

  // Device command, then poll until the link is idle again
  task automatic cmd(input logic cfg, input logic [7:0] d);
    int n;
    xfer(1'b1, `OFS_COMMAND, {23'h0, cfg, d});
    n = 0;
    do begin
      xfer(1'b0, `OFS_STATUS, 32'h0);
      n++;
    end while (rd[`HST_BUSY_BIT] !== 1'b0 && n < 20);
    if (rd[`HST_BUSY_BIT] !== 1'b0) begin
      error_cnt++;
      summarize();
    end
  endtask : cmd

  task automatic st(input int b, input logic exp);
    xfer(1'b0, `OFS_STATUS, 32'h0);
    chk(rd[`HST_DEV_LSB + b], exp);
  endtask : st

  // Overall run limit
  initial begin
    repeat (20000) @(posedge hclk);
    error_cnt++;
    summarize();
  end

  // Main sequence
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    htrans = 2'b00;
    hwrite = 1'b0;
    haddr = 32'h0;
    hwdata = 32'h0;
    pack_at_wake = 1'b0;
    cell_low = 4'h0;
    cell_rel = 4'hf;
    cell_gate = 4'hf;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    tick(3);
    chk({dsg_drv, chg_drv, reg_out}, 3'b001);
    xfer(1'b0, `OFS_CONTROL_RB, 32'h0);
    chk(rd[7:0], `CTL_RESET);
    xfer(1'b0, 8'h20, 32'h0);
    chk(rd, 32'h0);
    // Every level select code reaches the outputs
    for (int k = 0; k < 4; k++) begin
      cmd(1'b1, {4'h0, k[1:0], k[1:0]});
      chk({uv_sel, gate_sel}, {k[1:0], k[1:0]});
    end
    xfer(1'b0, `OFS_CONFIG_RB, 32'h0);
    chk(rd[7:0], 8'h0f);
    // Sleep request ignored while pack is at wake level
    pack_at_wake <= 1'b1;
    cmd(1'b0, 8'h07);
    st(`ST_ASLEEP_BIT, 1'b0);
    chk({dsg_drv, chg_drv}, 2'b00);
    pack_at_wake <= 1'b0;
    // Short dip cancels the detection timer
    cell_low <= 4'h2;
    tick(2);
    st(`ST_DETECT_BIT, 1'b1);
    tick(DET - 9);
    cell_low <= 4'h0;
    tick(DET + 5);
    chk({dsg_drv, chg_drv}, 2'b00);
    // Long dip: FETs off only after the full delay, then sleep
    cell_low <= 4'h8;
    cell_rel <= 4'h0;
    cell_gate <= 4'h0;
    tick(DET - 2);
    chk(dsg_drv, 1'b0);
    tick(8);
    chk({dsg_drv, chg_drv, reg_out}, 3'b110);
    cell_low <= 4'h0;
    cmd(1'b1, 8'h10);
    chk(rd[`HST_REFUSED_BIT], 1'b1);
    st(`ST_ASLEEP_BIT, 1'b1);
    // Wake on pack level, then the wake reset runs out
    pack_at_wake <= 1'b1;
    tick(3);
    chk(reg_out, 1'b1);
    st(`ST_WAKING_BIT, 1'b1);
    tick(WAKE);
    st(`ST_WAKING_BIT, 1'b0);
    // Cells under the gate level lock the FETs until the check is off
    cmd(1'b0, 8'h01);
    chk({dsg_drv, chg_drv}, 2'b11);
    st(`ST_LOCK_BIT, 1'b1);
    cmd(1'b1, 8'h10);
    cmd(1'b0, 8'h01);
    chk({dsg_drv, chg_drv}, 2'b10);
    cmd(1'b0, 8'h03);
    chk(dsg_drv, 1'b1);
    // Release timer keeps protection until it completes
    cell_rel <= 4'hf;
    tick(2);
    st(`ST_OD_BIT, 1'b1);
    tick(REL + 4);
    st(`ST_OD_BIT, 1'b0);
    chk(dsg_drv, 1'b1);
    cmd(1'b0, 8'h03);
    chk({dsg_drv, chg_drv}, 2'b00);
    // Controller sleep request with pack low
    pack_at_wake <= 1'b0;
    cmd(1'b0, 8'h07);
    tick(3);
    chk({dsg_drv, chg_drv, reg_out}, 3'b110);
    st(`ST_ASLEEP_BIT, 1'b1);
    chk(hresp, 1'b0);
    summarize();
  end
endmodule : over_discharge_sleep_control_tb_top

// >>> verification/sleep_link_asserts.sv
// Purpose: Checks on the command link between the two ends
// Assumes: One clock domain, asynchronous active-low reset
// Notes:   Sees only the shared link signals
`timescale 1ns/1ns
module sleep_link_asserts (
  input wire logic                 hclk,
  input wire logic                 hresetn,
  input wire logic                 cmd_valid,
  input wire logic                 cmd_is_config,
  input wire sleep_ctl_pkg::byte_t cmd_data,
  input wire logic                 cmd_done,
  input wire logic                 cmd_refused,
  input wire sleep_ctl_pkg::byte_t dev_status,
  input wire sleep_ctl_pkg::byte_t dev_config,
  input wire sleep_ctl_pkg::byte_t dev_control
);
  import sleep_ctl_pkg::*;
  default clocking @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // Handshake steps: device takes a request, then answers it
  sequence s_take;
    cmd_valid && !cmd_done;
  endsequence
  sequence s_cfg_ok;
    cmd_done && !cmd_refused && cmd_is_config;
  endsequence

  // Answer comes exactly one cycle after the request is taken
  property p_answer;
    s_take |=> cmd_done;
  endproperty
  a_answer: assert property (p_answer)
    else $error("link answer missing one cycle after take");
  property p_done_pulse;
    cmd_done |=> !cmd_done;
  endproperty
  a_done_pulse: assert property (p_done_pulse)
    else $error("link done longer than one cycle");
  // Refusal only as part of an answer
  property p_refuse_tag;
    cmd_refused |-> cmd_done;
  endproperty
  a_refuse_tag: assert property (p_refuse_tag)
    else $error("refused without done");
  // Asleep device refuses, awake device accepts
  property p_refuse_asleep;
    s_take ##0 dev_status[0] |=> cmd_refused;
  endproperty
  a_refuse_asleep: assert property (p_refuse_asleep)
    else $error("command accepted while asleep");
  property p_accept_awake;
    s_take ##0 !dev_status[0] |=> !cmd_refused;
  endproperty
  a_accept_awake: assert property (p_accept_awake)
    else $error("command refused while awake");
  // Sleep entry drops both FET enables
  property p_sleep_off;
    $rose(dev_status[0]) |-> ##[0:1] (dev_control[1:0] == 2'b00);
  endproperty
  a_sleep_off: assert property (p_sleep_off)
    else $error("FET enables kept across sleep entry");
  // Leaving sleep always passes through wake reset
  property p_wake_reset;
    $fell(dev_status[0]) |-> ##[0:1] dev_status[1];
  endproperty
  a_wake_reset: assert property (p_wake_reset)
    else $error("wake without wake reset");
  // Protection only after the detection timer ran
  property p_od_detect;
    $rose(dev_status[2]) |-> $past(dev_status[4]);
  endproperty
  a_od_detect: assert property (p_od_detect)
    else $error("protection without detection timer");
  // Accepted config write lands in the config register
  property p_cfg_store;
    s_cfg_ok |=> (dev_config[4:0] == $past(cmd_data[4:0]));
  endproperty
  a_cfg_store: assert property (p_cfg_store)
    else $error("config write not stored");
endmodule : sleep_link_asserts
